// ===== src/dled_pkg.sv
/*
 * Package for the diagnostic indicator encoder: register map, colour and
 * state types, status carriers and blink timing.
 * Assumes a 200 MHz system clock; all users refer to names as dled_pkg::name.
 */
package dled_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_FAULT = 8'h08;

    // Field positions.
    localparam int CTRL_OVR_DIS_BIT = 0;
    localparam int CTRL_FLT_CLR_BIT = 1;
    localparam int FAULT_VALID_BIT = 16;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Fault codes and arguments of the red flash sequence.
    localparam logic [7:0] FC_NVM = 8'h01;
    localparam logic [7:0] FA_NVM_CKSUM = 8'h00;
    localparam logic [7:0] FA_TBL_OVF = 8'h01;
    localparam logic [7:0] FA_BAD_TYPE = 8'h02;
    localparam logic [7:0] FC_CMD = 8'h03;
    localparam logic [7:0] FA_CMD = 8'h00;
    localparam logic [7:0] FC_DATA = 8'h04;
    localparam logic [7:0] FC_INIT = 8'h06;
    localparam logic [7:0] FA_SW_CHANGED = 8'h02;
    localparam logic [7:0] FC_CYCLE = 8'h07;
    localparam logic [7:0] FA_CYCLE = 8'h00;

    // Timing: blink half period in ms and the derived cycle count.
    localparam int CLK_MHZ = 200;
    localparam int BLINK_HALF_MS = 250;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_MHZ * 1000;
    localparam logic [7:0] GAP_TICKS = 8'h02;
    localparam logic [7:0] PAUSE_TICKS = 8'h06;

    typedef enum logic [1:0] {COL_OFF, COL_GREEN, COL_ORANGE, COL_RED} dled_col_e;

    typedef enum logic [2:0] {
        BUS_NONE, BUS_NO_LINK, BUS_COMM_ERR, BUS_BAUD_SEARCH, BUS_WAIT_MASTER, BUS_ACTIVE
    } dled_bus_e;

    typedef enum logic [1:0] {PRG_STOP, PRG_RUN_NOBOOT, PRG_GEN_BOOT, PRG_RUN_BOOT} dled_prg_e;

    typedef enum logic [1:0] {SQ_CODE, SQ_GAP, SQ_ARG, SQ_PAUSE} dled_seq_e;

    typedef struct packed {
        dled_prg_e state;
        logic in_cycle;
        logic ovr_some;
        logic ovr_all;
    } dled_prg_s;

    typedef struct packed {
        logic chk_done;
        logic chk_ok;
        logic running;
        logic access;
    } dled_kbus_s;

    // One-cycle fault events from the terminal-bus unit.
    typedef struct packed {
        logic nvm_cksum;
        logic tbl_ovf;
        logic bad_type;
        logic cmd_err;
        logic brk;
        logic [7:0] brk_after;
        logic cyc_over;
        logic sw_changed;
    } dled_kflt_s;

endpackage

// ===== src/dled_encoder.sv
/*
 * Diagnostic indicator group: drives the fieldbus, program and I/O
 * indicators and holds the terminal-bus fault for red flash display.
 * Assumes status inputs come from units on the same clock and an APB master
 * on the same clock. All outputs are registered.
 */
// Notes on behaviour
// - I/O indicator off after successful start-up check.
// - Terminal fault lights I/O red, type stored.
// - Every indicator has off, green, orange, red.
// - Fieldbus off unconnected, steady red link faults.
// - Fieldbus flashes red on communication timeout.
// - Fieldbus flashes orange during baud search.
// - Fieldbus flashes green waiting, green when active.
// - Program indicator off when stopped or empty.
// - Program flashes red on occasional overrun.
// - Program steady red when every cycle overruns.
// - Running without boot image: orange during cycle.
// - Generating boot image: program flashes orange.
// - Running from boot image: green during cycle.
// - I/O off when terminal bus idle.
// - I/O orange during register or tool access.
// - I/O green while terminal bus cycles.
// - Code 1 arguments: checksum, overflow, data type.
// - Command error reports code 3, argument 0.
// - Break after controller reports code 4, argument 0.
// - Break after terminal n reports code 4, n.
// - Code 7 cycle overrun held until reset.
// - Switches changed report code 6, argument 2.
`timescale 1ns/100ps
`default_nettype none

module dled_encoder #(
    parameter int BLINK_HALF_CYC = dled_pkg::BLINK_HALF_CYC
) (
    // Clock and reset.
    input wire logic CLK_SYS_IN,
    input wire logic RSTN_IN,
    // APB slave.
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Status from the fieldbus, program and terminal-bus units.
    input wire dled_pkg::dled_bus_e BUS_STATE_IN,
    input wire dled_pkg::dled_prg_s PRG_STATUS_IN,
    input wire dled_pkg::dled_kbus_s KBUS_STATUS_IN,
    input wire dled_pkg::dled_kflt_s KBUS_FAULT_IN,
    // Indicator colours.
    output dled_pkg::dled_col_e BUS_LED_OUT,
    output dled_pkg::dled_col_e PRG_LED_OUT,
    output dled_pkg::dled_col_e IO_LED_OUT
);

    logic [25:0] blink_cnt_r;
    logic blink_on_r;
    logic tick;
    logic [31:0] ctrl_r;
    logic wr_acc;
    logic flt_clr;
    logic flt_v_r;
    logic [7:0] flt_code_r;
    logic [7:0] flt_arg_r;
    logic flt_lock;
    logic evt_v;
    logic [7:0] evt_code;
    logic [7:0] evt_arg;
    dled_pkg::dled_seq_e seq_r;
    logic [7:0] seq_cnt_r;
    logic seq_half_r;
    logic seq_lit_r;
    logic seq_restart;
    dled_pkg::dled_col_e bus_nxt;
    dled_pkg::dled_col_e prg_nxt;
    dled_pkg::dled_col_e io_nxt;

    // Shared blink timer; tick marks each half period.
    assign tick = (blink_cnt_r == 26'(BLINK_HALF_CYC - 1));

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            blink_cnt_r <= 26'h0;
            blink_on_r <= 1'b0;
        end else if (tick) begin
            blink_cnt_r <= 26'h0;
            blink_on_r <= ~blink_on_r;
        end else begin
            blink_cnt_r <= blink_cnt_r + 26'h1;
        end
    end

    // APB slave: no wait states, answer registered in the setup phase.
    assign wr_acc = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
    assign flt_clr = wr_acc && (PADDR_IN == dled_pkg::REG_CTRL)
        && PWDATA_IN[dled_pkg::CTRL_FLT_CLR_BIT];

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0;
        end else begin
            PREADY_OUT <= PSEL_IN && !PENABLE_IN;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0;
            if (PSEL_IN && !PENABLE_IN) begin
                if (PADDR_IN == dled_pkg::REG_CTRL) begin
                    PRDATA_OUT <= ctrl_r;
                end else if (PADDR_IN == dled_pkg::REG_STATUS) begin
                    PRDATA_OUT <= {24'h0, KBUS_STATUS_IN.chk_done, blink_on_r,
                        IO_LED_OUT, PRG_LED_OUT, BUS_LED_OUT};
                end else if (PADDR_IN == dled_pkg::REG_FAULT) begin
                    PRDATA_OUT <= {15'h0, flt_v_r, flt_code_r, flt_arg_r};
                end else begin
                    PSLVERR_OUT <= 1'b1;
                end
            end
        end
    end

    // Control register: bit 0 hides program overrun, bit 1 is self-clearing.
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            ctrl_r <= dled_pkg::CTRL_RESET;
        end else if (wr_acc && PADDR_IN == dled_pkg::REG_CTRL) begin
            ctrl_r <= {31'h0, PWDATA_IN[dled_pkg::CTRL_OVR_DIS_BIT]};
        end
    end

    // Fault event to code and argument, cycle overrun first.
    always_comb begin
        evt_v = 1'b1;
        evt_code = dled_pkg::FC_CMD;
        evt_arg = dled_pkg::FA_CMD;
        if (KBUS_FAULT_IN.cyc_over) begin
            evt_code = dled_pkg::FC_CYCLE;
            evt_arg = dled_pkg::FA_CYCLE;
        end else if (KBUS_FAULT_IN.nvm_cksum) begin
            evt_code = dled_pkg::FC_NVM;
            evt_arg = dled_pkg::FA_NVM_CKSUM;
        end else if (KBUS_FAULT_IN.tbl_ovf) begin
            evt_code = dled_pkg::FC_NVM;
            evt_arg = dled_pkg::FA_TBL_OVF;
        end else if (KBUS_FAULT_IN.bad_type) begin
            evt_code = dled_pkg::FC_NVM;
            evt_arg = dled_pkg::FA_BAD_TYPE;
        end else if (KBUS_FAULT_IN.cmd_err) begin
            evt_code = dled_pkg::FC_CMD;
            evt_arg = dled_pkg::FA_CMD;
        end else if (KBUS_FAULT_IN.brk) begin
            evt_code = dled_pkg::FC_DATA;
            evt_arg = KBUS_FAULT_IN.brk_after;
        end else if (KBUS_FAULT_IN.sw_changed) begin
            evt_code = dled_pkg::FC_INIT;
            evt_arg = dled_pkg::FA_SW_CHANGED;
        end else if (KBUS_STATUS_IN.chk_done && !KBUS_STATUS_IN.chk_ok && !flt_v_r) begin
            evt_code = dled_pkg::FC_CMD;
            evt_arg = dled_pkg::FA_CMD;
        end else begin
            evt_v = 1'b0;
        end
    end

    // A cycle overrun fault stays until reset; nothing replaces or clears it.
    assign flt_lock = flt_v_r && (flt_code_r == dled_pkg::FC_CYCLE);
    assign seq_restart = evt_v && !flt_lock;

    // Fault holder; a new event wins over a clear in the same cycle.
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            flt_v_r <= 1'b0;
            flt_code_r <= 8'h0;
            flt_arg_r <= 8'h0;
        end else if (seq_restart) begin
            flt_v_r <= 1'b1;
            flt_code_r <= evt_code;
            flt_arg_r <= evt_arg;
        end else if (flt_clr && !flt_lock) begin
            flt_v_r <= 1'b0;
        end
    end

    // Red flash sequencer: code burst, gap, argument burst, pause.
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN || !flt_v_r || seq_restart) begin
            seq_r <= dled_pkg::SQ_CODE;
            seq_cnt_r <= 8'h0;
            seq_half_r <= 1'b0;
            seq_lit_r <= 1'b0;
        end else if (tick) begin
            case (seq_r)
                dled_pkg::SQ_CODE, dled_pkg::SQ_ARG: begin
                    if (seq_cnt_r == ((seq_r == dled_pkg::SQ_CODE) ? flt_code_r : flt_arg_r)) begin
                        seq_r <= (seq_r == dled_pkg::SQ_CODE) ? dled_pkg::SQ_GAP
                            : dled_pkg::SQ_PAUSE;
                        seq_cnt_r <= 8'h0;
                    end else if (!seq_half_r) begin
                        seq_half_r <= 1'b1;
                        seq_lit_r <= 1'b1;
                    end else begin
                        seq_half_r <= 1'b0;
                        seq_lit_r <= 1'b0;
                        seq_cnt_r <= seq_cnt_r + 8'h1;
                    end
                end
                dled_pkg::SQ_GAP: begin
                    if (seq_cnt_r == dled_pkg::GAP_TICKS - 8'h1) begin
                        seq_r <= dled_pkg::SQ_ARG;
                        seq_cnt_r <= 8'h0;
                    end else begin
                        seq_cnt_r <= seq_cnt_r + 8'h1;
                    end
                end
                default: begin
                    if (seq_cnt_r == dled_pkg::PAUSE_TICKS - 8'h1) begin
                        seq_r <= dled_pkg::SQ_CODE;
                        seq_cnt_r <= 8'h0;
                    end else begin
                        seq_cnt_r <= seq_cnt_r + 8'h1;
                    end
                end
            endcase
        end
    end

    // Fieldbus indicator.
    always_comb begin
        case (BUS_STATE_IN)
            dled_pkg::BUS_NO_LINK: bus_nxt = dled_pkg::COL_RED;
            dled_pkg::BUS_COMM_ERR: bus_nxt = blink_on_r ? dled_pkg::COL_RED
                : dled_pkg::COL_OFF;
            dled_pkg::BUS_BAUD_SEARCH: bus_nxt = blink_on_r ? dled_pkg::COL_ORANGE
                : dled_pkg::COL_OFF;
            dled_pkg::BUS_WAIT_MASTER: bus_nxt = blink_on_r ? dled_pkg::COL_GREEN
                : dled_pkg::COL_OFF;
            dled_pkg::BUS_ACTIVE: bus_nxt = dled_pkg::COL_GREEN;
            default: bus_nxt = dled_pkg::COL_OFF;
        endcase
    end

    // Program indicator; overrun display can be hidden by software.
    always_comb begin
        prg_nxt = dled_pkg::COL_OFF;
        if (PRG_STATUS_IN.state == dled_pkg::PRG_STOP) begin
            prg_nxt = dled_pkg::COL_OFF;
        end else if (PRG_STATUS_IN.ovr_all && !ctrl_r[dled_pkg::CTRL_OVR_DIS_BIT]) begin
            prg_nxt = dled_pkg::COL_RED;
        end else if (PRG_STATUS_IN.ovr_some && !ctrl_r[dled_pkg::CTRL_OVR_DIS_BIT]) begin
            prg_nxt = blink_on_r ? dled_pkg::COL_RED : dled_pkg::COL_OFF;
        end else if (PRG_STATUS_IN.state == dled_pkg::PRG_GEN_BOOT) begin
            prg_nxt = blink_on_r ? dled_pkg::COL_ORANGE : dled_pkg::COL_OFF;
        end else if (PRG_STATUS_IN.in_cycle) begin
            prg_nxt = (PRG_STATUS_IN.state == dled_pkg::PRG_RUN_BOOT)
                ? dled_pkg::COL_GREEN : dled_pkg::COL_ORANGE;
        end
    end

    // I/O indicator; orange until the start-up check completes.
    always_comb begin
        if (flt_v_r) begin
            io_nxt = seq_lit_r ? dled_pkg::COL_RED : dled_pkg::COL_OFF;
        end else if (!KBUS_STATUS_IN.chk_done || KBUS_STATUS_IN.access) begin
            io_nxt = dled_pkg::COL_ORANGE;
        end else if (KBUS_STATUS_IN.running) begin
            io_nxt = dled_pkg::COL_GREEN;
        end else begin
            io_nxt = dled_pkg::COL_OFF;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            BUS_LED_OUT <= dled_pkg::COL_OFF;
            PRG_LED_OUT <= dled_pkg::COL_OFF;
            IO_LED_OUT <= dled_pkg::COL_OFF;
        end else begin
            BUS_LED_OUT <= bus_nxt;
            PRG_LED_OUT <= prg_nxt;
            IO_LED_OUT <= io_nxt;
        end
    end

    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RSTN_IN);

    sequence s_idle_ok;
        !flt_v_r && KBUS_STATUS_IN.chk_done && !KBUS_STATUS_IN.access
            && !KBUS_STATUS_IN.running;
    endsequence

    property p_io_off_ok;
        s_idle_ok |=> IO_LED_OUT == dled_pkg::COL_OFF;
    endproperty
    a_io_off_ok: assert property (p_io_off_ok) else $error("I/O not off");

    property p_io_red;
        flt_v_r && seq_lit_r |=> IO_LED_OUT == dled_pkg::COL_RED;
    endproperty
    a_io_red: assert property (p_io_red) else $error("I/O not red on fault");

    property p_cyc_lock;
        flt_lock |=> flt_v_r && flt_code_r == dled_pkg::FC_CYCLE && $stable(flt_arg_r);
    endproperty
    a_cyc_lock: assert property (p_cyc_lock) else $error("cycle fault lost");

    property p_brk;
        !flt_lock && KBUS_FAULT_IN.brk && !KBUS_FAULT_IN.cyc_over && !KBUS_FAULT_IN.nvm_cksum
            && !KBUS_FAULT_IN.tbl_ovf && !KBUS_FAULT_IN.bad_type && !KBUS_FAULT_IN.cmd_err
            |=> flt_code_r == dled_pkg::FC_DATA && flt_arg_r == $past(KBUS_FAULT_IN.brk_after);
    endproperty
    a_brk: assert property (p_brk) else $error("break fault wrong");

    property p_sw_chg;
        !flt_lock && KBUS_FAULT_IN.sw_changed && !KBUS_FAULT_IN.brk && !KBUS_FAULT_IN.cyc_over
            && !KBUS_FAULT_IN.cmd_err && !KBUS_FAULT_IN.nvm_cksum && !KBUS_FAULT_IN.tbl_ovf
            && !KBUS_FAULT_IN.bad_type |=> flt_code_r == 8'h06 && flt_arg_r == 8'h02;
    endproperty
    a_sw_chg: assert property (p_sw_chg) else $error("switch fault wrong");

    property p_bus_green;
        BUS_STATE_IN == dled_pkg::BUS_ACTIVE |=> BUS_LED_OUT == dled_pkg::COL_GREEN;
    endproperty
    a_bus_green: assert property (p_bus_green) else $error("bus not green");

    property p_bus_red_flash;
        BUS_STATE_IN == dled_pkg::BUS_COMM_ERR
            |=> BUS_LED_OUT == ($past(blink_on_r) ? dled_pkg::COL_RED : dled_pkg::COL_OFF);
    endproperty
    a_bus_red_flash: assert property (p_bus_red_flash) else $error("bus flash wrong");

    property p_prg_off;
        PRG_STATUS_IN.state == dled_pkg::PRG_STOP |=> PRG_LED_OUT == dled_pkg::COL_OFF;
    endproperty
    a_prg_off: assert property (p_prg_off) else $error("program not off");

    property p_blink;
        tick |=> blink_on_r != $past(blink_on_r) && blink_cnt_r == 26'h0;
    endproperty
    a_blink: assert property (p_blink) else $error("blink timer wrong");

    property p_apb_ready;
        PSEL_IN && !PENABLE_IN |=> PREADY_OUT;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("no APB answer");

    // A flash starts on a tick while the burst count is still short of its target.
    sequence s_flash_start;
        flt_v_r && !seq_restart && tick && !seq_half_r
            && (seq_r == dled_pkg::SQ_CODE || seq_r == dled_pkg::SQ_ARG)
            && seq_cnt_r != ((seq_r == dled_pkg::SQ_CODE) ? flt_code_r : flt_arg_r);
    endsequence

    sequence s_code_done;
        flt_v_r && !seq_restart && tick && seq_r == dled_pkg::SQ_CODE
            && seq_cnt_r == flt_code_r;
    endsequence

    property p_flash_on;
        s_flash_start |=> seq_lit_r && seq_half_r;
    endproperty
    a_flash_on: assert property (p_flash_on) else $error("flash did not start");

    property p_code_gap;
        s_code_done |=> seq_r == dled_pkg::SQ_GAP && seq_cnt_r == 8'h0 && !seq_lit_r;
    endproperty
    a_code_gap: assert property (p_code_gap) else $error("no gap after code");

endmodule

`default_nettype wire

// ===== sim/dled_panel.sv
/*
 * Front-panel model: an operator who counts the red flash bursts of the I/O indicator.
 * Assumes the indicator colour changes only on the system clock.
 */
`timescale 1ns/100ps
`default_nettype none

module dled_panel #(
    parameter int HALF_CYC = 4
) (
    // Clock, reset and restart of the count.
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic clr_in,
    // Indicator being watched.
    input wire dled_pkg::dled_col_e io_led_in
);
    int run_r;
    int off_r;
    logic red_r;
    int bursts[$];

    // A dark spell of HALF_CYC + 3 cycles, longer than one blink half period, closes a burst.
    always @(posedge clk_in) begin
        red_r <= (io_led_in == dled_pkg::COL_RED);
        if (!rstn_in || clr_in) begin
            run_r <= 0;
            off_r <= 0;
            bursts.delete();
        end else if (io_led_in == dled_pkg::COL_RED) begin
            off_r <= 0;
            if (!red_r) run_r <= run_r + 1;
        end else begin
            off_r <= off_r + 1;
            if (off_r == HALF_CYC + 2 && run_r > 0) begin
                bursts.push_back(run_r);
                run_r <= 0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== sim/dled_encoder_tb.sv
/*
 * Self-checking testbench for the diagnostic indicator encoder.
 * Assumes a short blink half period, set through the design parameter.
 */
`timescale 1ns/100ps
`default_nettype none

module dled_encoder_tb;
    localparam int HALF = 4;
    logic clk, rstn, psel, penable, pwrite, clr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, er;
    dled_pkg::dled_bus_e bus_st;
    dled_pkg::dled_prg_s prg;
    dled_pkg::dled_kbus_s kbus;
    dled_pkg::dled_kflt_s flt;
    dled_pkg::dled_col_e bus_led, prg_led, io_led;
    int n_fail, total_checks, cyc;

    dled_encoder #(.BLINK_HALF_CYC(HALF)) DUT (
        .CLK_SYS_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .BUS_STATE_IN(bus_st),
        .PRG_STATUS_IN(prg), .KBUS_STATUS_IN(kbus), .KBUS_FAULT_IN(flt),
        .BUS_LED_OUT(bus_led), .PRG_LED_OUT(prg_led), .IO_LED_OUT(io_led)
    );
    dled_panel #(.HALF_CYC(HALF)) panel (
        .clk_in(clk), .rstn_in(rstn), .clr_in(clr), .io_led_in(io_led)
    );

    task automatic end_sim();
        if (n_fail == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Watches one indicator for three half periods, steady or flashing.
    task automatic chk_led(input int w, input dled_pkg::dled_col_e col, input bit fl);
        dled_pkg::dled_col_e v;
        bit on, off, bad;
        on = 0;
        off = 0;
        bad = 0;
        repeat (3 * HALF) begin
            @(negedge clk);
            v = (w == 0) ? bus_led : (w == 1) ? prg_led : io_led;
            if (v === col) on = 1;
            else if (v === dled_pkg::COL_OFF) off = 1;
            else bad = 1;
        end
        chk_val({29'h0, on, off, bad}, {29'h0, 1'b1, fl, 1'b0}, $sformatf("led %0d", w));
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        chk_val(n, 1, "pready late");
    endtask

    task automatic set_prg(input dled_pkg::dled_prg_e s, input logic c, o, a);
        @(posedge clk) prg <= '{s, c, o, a};
        settle();
    endtask

    // Pulses one fault event and reads back the held code and argument.
    task automatic fire(input dled_pkg::dled_kflt_s f, input logic [7:0] c, a);
        @(posedge clk);
        flt <= f;
        clr <= 1;
        // Two clear cycles hide a flash left over from the fault being replaced.
        @(posedge clk) flt <= '0;
        @(posedge clk) clr <= 0;
        apb(0, dled_pkg::REG_FAULT, 0);
        chk_val(rd, {15'h0, 1'b1, c, a}, "fault reg");
    endtask

    task automatic t_io();
        chk_led(2, dled_pkg::COL_ORANGE, 0);
        @(posedge clk) kbus <= '{1, 1, 0, 0};
        settle();
        chk_led(2, dled_pkg::COL_OFF, 0);
        @(posedge clk) kbus <= '{1, 1, 1, 0};
        settle();
        chk_led(2, dled_pkg::COL_GREEN, 0);
        @(posedge clk) kbus <= '{1, 1, 1, 1};
        settle();
        chk_led(2, dled_pkg::COL_ORANGE, 0);
        @(posedge clk) kbus <= '{1, 1, 1, 0};
    endtask

    task automatic t_bus();
        dled_pkg::dled_bus_e st[6] = '{dled_pkg::BUS_NONE, dled_pkg::BUS_NO_LINK,
            dled_pkg::BUS_COMM_ERR, dled_pkg::BUS_BAUD_SEARCH, dled_pkg::BUS_WAIT_MASTER,
            dled_pkg::BUS_ACTIVE};
        dled_pkg::dled_col_e col[6] = '{dled_pkg::COL_OFF, dled_pkg::COL_RED,
            dled_pkg::COL_RED, dled_pkg::COL_ORANGE, dled_pkg::COL_GREEN, dled_pkg::COL_GREEN};
        bit fl[6] = '{0, 0, 1, 1, 1, 0};
        for (int i = 0; i < 6; i++) begin
            @(posedge clk) bus_st <= st[i];
            settle();
            chk_led(0, col[i], fl[i]);
        end
        @(posedge clk) bus_st <= dled_pkg::BUS_COMM_ERR;
        set_prg(dled_pkg::PRG_GEN_BOOT, 0, 0, 0);
        repeat (3 * HALF) begin
            @(negedge clk);
            chk_val(bus_led == dled_pkg::COL_OFF, prg_led == dled_pkg::COL_OFF, "phase");
        end
    endtask

    task automatic t_prg();
        chk_led(1, dled_pkg::COL_ORANGE, 1);
        set_prg(dled_pkg::PRG_STOP, 1, 0, 1);
        chk_led(1, dled_pkg::COL_OFF, 0);
        set_prg(dled_pkg::PRG_RUN_NOBOOT, 1, 0, 0);
        chk_led(1, dled_pkg::COL_ORANGE, 0);
        set_prg(dled_pkg::PRG_RUN_NOBOOT, 0, 0, 0);
        chk_led(1, dled_pkg::COL_OFF, 0);
        set_prg(dled_pkg::PRG_RUN_BOOT, 1, 0, 0);
        chk_led(1, dled_pkg::COL_GREEN, 0);
        set_prg(dled_pkg::PRG_RUN_BOOT, 1, 1, 0);
        chk_led(1, dled_pkg::COL_RED, 1);
        set_prg(dled_pkg::PRG_RUN_BOOT, 1, 1, 1);
        chk_led(1, dled_pkg::COL_RED, 0);
        apb(1, dled_pkg::REG_CTRL, 32'h3);
        apb(0, dled_pkg::REG_CTRL, 0);
        chk_val(rd, 32'h1, "ctrl rb");
        chk_led(1, dled_pkg::COL_GREEN, 0);
        apb(1, dled_pkg::REG_CTRL, 32'h0);
    endtask

    task automatic t_regs();
        apb(0, dled_pkg::REG_STATUS, 0);
        chk_val(rd & 32'hb0, 32'h90, "status");
        apb(1, 8'h0c, 32'hffff_ffff);
        chk_val({31'h0, er}, 32'h1, "slverr wr");
        apb(0, 8'h0c, 0);
        chk_val({rd[30:0], er}, 32'h1, "slverr rd");
    endtask

    task automatic t_faults();
        fire('{1, 0, 0, 0, 0, 8'h00, 0, 0}, 8'h01, 8'h00);
        chk_led(2, dled_pkg::COL_RED, 1);
        fire('{0, 1, 0, 0, 0, 8'h00, 0, 0}, 8'h01, 8'h01);
        fire('{0, 0, 1, 0, 0, 8'h00, 0, 0}, 8'h01, 8'h02);
        fire('{0, 0, 0, 1, 0, 8'h00, 0, 0}, 8'h03, 8'h00);
        fire('{0, 0, 0, 0, 1, 8'h00, 0, 0}, 8'h04, 8'h00);
        fire('{0, 0, 0, 0, 0, 8'h00, 0, 1}, 8'h06, 8'h02);
        fire('{0, 0, 0, 0, 1, 8'h02, 0, 0}, 8'h04, 8'h02);
        for (int n = 0; n < 200 && panel.bursts.size() < 2; n++) @(posedge clk);
        chk_val(panel.bursts.size() > 1 ? panel.bursts[0] : 0, 4, "code burst");
        chk_val(panel.bursts.size() > 1 ? panel.bursts[1] : 0, 2, "arg burst");
        apb(1, dled_pkg::REG_CTRL, 32'h2);
        apb(0, dled_pkg::REG_FAULT, 0);
        chk_val(rd, 32'h0000_0402, "cleared");
        @(posedge clk) kbus <= '{1, 0, 1, 0};
        @(posedge clk) kbus <= '{1, 1, 1, 0};
        apb(0, dled_pkg::REG_FAULT, 0);
        chk_val(rd, 32'h0001_0300, "start-up fault");
        fire('{0, 0, 0, 0, 0, 8'h00, 1, 0}, 8'h07, 8'h00);
        apb(1, dled_pkg::REG_CTRL, 32'h2);
        fire('{0, 0, 0, 1, 0, 8'h00, 0, 0}, 8'h07, 8'h00);
    endtask

    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        {rstn, psel, penable, pwrite, clr, paddr, pwdata} = '0;
        bus_st = dled_pkg::BUS_NONE;
        {prg, kbus, flt} = '0;
        {n_fail, total_checks, cyc} = '0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        chk_val({26'h0, bus_led, prg_led, io_led}, 32'h0, "reset leds");
        @(posedge clk) rstn <= 1;
        settle();
        t_io();
        t_bus();
        t_prg();
        t_regs();
        t_faults();
        end_sim();
    end
endmodule
`default_nettype wire
